// ### hdl/osr_top.sv
// Octal converter output path: sampling pipeline, buffer, serial lanes.
// Assumes a fast link clock supplied by the serial clock generator.
//
// Overview of operation
// - All eight channels are sampled together on the rising sample clock edge.
// - Each sample appears after a fixed pipeline of 11 sample clocks.
// - Fourteen result bits go out on one lane, or split over two.
// - Dual-lane mode halves bits per lane, for high sample rates.
// - Bit clock runs 7x and frame clock 1x sample rate, 14-bit single-lane mode.
// - Word length selectable 14, 12 or 10; only those bits are sent, except on lane 2c+1 in single-lane mode.
// - Decimation in single-lane mode sends 14 bits per sample.
`timescale 1ns/1ps
`default_nettype none
module osr_top
    import osr_pkg::*;
#(
    parameter int NCHAN = NCH,
    parameter int LAT = LATENCY
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NCHAN*RES_W-1:0] ana_code,
    input wire osr_res_e res_sel,
    input wire logic dual_lane,
    input wire logic decim_en,
    input wire logic lclk,
    output logic [2*NCHAN-1:0] lane_out,
    output logic bit_clk,
    output logic frame_clk,
    output logic accept
);
    localparam int SW = NCHAN * RES_W;
    localparam int WW = SW + CFG_W;

    osr_word_if #(.DW(SW)) dl_if();
    osr_word_if #(.DW(WW)) bf_in();
    osr_word_if #(.DW(WW)) bf_out();

    // Sample clock domain state
    typedef struct packed {
        osr_tx_e st;
        logic req;
        logic [1:0] ack_sync;
        logic [WW-1:0] hold;
        logic accept;
    } osr_m_s;

    // Link clock domain state
    typedef struct packed {
        logic [1:0] rst_sync;
        logic [1:0] req_sync;
        logic ack;
        logic nw_vld;
        logic [WW-1:0] nw;
        logic [WW-1:0] cur;
        logic [NCHAN-1:0][RES_W-1:0] sh;
        logic [BIT_W-1:0] cnt;
        logic [BIT_W-1:0] len;
        logic dual;
        logic bclk;
        logic fclk;
    } osr_l_s;

    osr_m_s mq;
    osr_m_s md;
    osr_l_s lq;
    osr_l_s ld;
    osr_res_e eff_res;

    osr_delay_line #(
        .DW(SW),
        .LAT(LAT)
    ) u_pipe (
        .clk(mclk),
        .rst(sys_rst),
        .din(ana_code),
        .dout(dl_if)
    );

    // Decimated single-lane output always carries full words
    assign eff_res = (decim_en && !dual_lane) ? RES_14 : res_sel;

    // Mode travels with each word so the link side never sees a torn mode
    assign bf_in.valid = dl_if.valid;
    assign bf_in.data = {eff_res, dual_lane, dl_if.data};
    assign dl_if.ready = bf_in.ready;

    osr_fifo #(
        .DW(WW),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clk(mclk),
        .rst(sys_rst),
        .wr(bf_in),
        .rd(bf_out)
    );

    assign bf_out.ready = (mq.st == TX_IDLE);

    // Toggle handshake toward the link: hold stays put until acknowledged
    always_comb
    begin
        md = mq;
        md.ack_sync = {mq.ack_sync[0], lq.ack};
        // Samples dropped while the buffer is full show as accept low
        md.accept = bf_in.ready;
        case (mq.st)
            TX_IDLE:
            begin
                if (bf_out.valid)
                begin
                    md.hold = bf_out.data;
                    md.req = ~mq.req;
                    md.st = TX_WAIT;
                end
            end
            TX_WAIT:
            begin
                if (mq.ack_sync[1] == mq.req)
                begin
                    md.st = TX_IDLE;
                end
            end
            default:
            begin
                md.st = TX_IDLE;
            end
        endcase
        if (sys_rst)
        begin
            md = '0;
        end
    end

    always_ff @(posedge mclk)
    begin
        mq <= md;
    end

    // Serializer on the link clock
    always_comb
    begin
        logic [SW-1:0] code;
        osr_res_e w_res;
        logic w_dual;
        logic [BIT_W-1:0] w_len;
        logic [BIT_W-1:0] sh_amt;
        code = '0;
        w_res = RES_14;
        w_dual = 1'b0;
        w_len = LEN_14;
        sh_amt = '0;
        ld = lq;
        ld.rst_sync = {lq.rst_sync[0], sys_rst};
        ld.req_sync = {lq.req_sync[0], mq.req};
        ld.bclk = ~lq.bclk;
        if (lq.req_sync[1] != lq.ack && !lq.nw_vld)
        begin
            ld.nw = mq.hold;
            ld.nw_vld = 1'b1;
            ld.ack = ~lq.ack;
        end
        if (lq.cnt == BIT_W'(lq.len - CNT_ONE))
        begin
            // Frame boundary: take a fresh word, or repeat the last one
            if (lq.nw_vld)
            begin
                ld.cur = lq.nw;
                ld.nw_vld = 1'b0;
            end
            {w_res, w_dual, code} = ld.cur;
            w_len = osr_lane_bits(w_res, w_dual);
            sh_amt = BIT_W'(HALF_W) - w_len;
            for (int c = 0; c < NCHAN; c++)
            begin
                if (w_dual)
                begin
                    ld.sh[c] = {code[c*RES_W+HALF_W +: HALF_W],
                                HALF_W'(code[c*RES_W +: RES_W] >> sh_amt)};
                end
                else
                begin
                    ld.sh[c] = code[c*RES_W +: RES_W];
                end
            end
            ld.len = w_len;
            ld.dual = w_dual;
            ld.cnt = '0;
        end
        else
        begin
            for (int c = 0; c < NCHAN; c++)
            begin
                if (lq.dual)
                begin
                    ld.sh[c] = {lq.sh[c][RES_W-2:HALF_W], 1'b0,
                                lq.sh[c][HALF_W-2:0], 1'b0};
                end
                else
                begin
                    ld.sh[c] = {lq.sh[c][RES_W-2:0], 1'b0};
                end
            end
            ld.cnt = BIT_W'(lq.cnt + CNT_ONE);
        end
        // Rises together with the first bit of every word
        ld.fclk = (ld.cnt < osr_frame_high(ld.len));
        if (lq.rst_sync[1])
        begin
            ld = '0;
            ld.rst_sync = {lq.rst_sync[0], sys_rst};
            ld.len = LEN_14;
            ld.cnt = BIT_W'(LEN_14 - CNT_ONE);
        end
    end

    always_ff @(posedge lclk)
    begin
        lq <= ld;
    end

    // Lane 2c+1 taps bit HALF_W-1, so it also carries the low bits in single-lane mode
    always_comb
    begin
        for (int c = 0; c < NCHAN; c++)
        begin
            lane_out[2*c] = lq.sh[c][RES_W-1];
            lane_out[2*c+1] = lq.sh[c][HALF_W-1];
        end
    end

    assign bit_clk = lq.bclk;
    assign frame_clk = lq.fclk;
    assign accept = mq.accept;
endmodule
`default_nettype wire

// ### hdl/osr_pkg.sv
// Shared constants and types for the octal converter serial output path.
// Assumes a sample clock and a separate serial link clock.
package osr_pkg;
    localparam int NCH = 8;
    localparam int RES_W = 14;
    localparam int HALF_W = RES_W / 2;
    localparam int LATENCY = 11;
    localparam int SAMPLE_W = NCH * RES_W;
    localparam int CFG_W = 3;
    localparam int WORD_W = SAMPLE_W + CFG_W;
    localparam int BUF_DEPTH = 2;
    localparam int BIT_W = 4;
    localparam logic [BIT_W-1:0] LEN_14 = 4'hE;
    localparam logic [BIT_W-1:0] LEN_12 = 4'hC;
    localparam logic [BIT_W-1:0] LEN_10 = 4'hA;
    localparam logic [BIT_W-1:0] CNT_ONE = 4'h1;

    typedef enum logic [1:0] {RES_14, RES_12, RES_10} osr_res_e;
    typedef enum logic {TX_IDLE, TX_WAIT} osr_tx_e;

    // Serial bits per lane for one sample word
    function automatic logic [BIT_W-1:0] osr_lane_bits(osr_res_e r, logic dual);
        logic [BIT_W-1:0] n;
        case (r)
            RES_12: n = LEN_12;
            RES_10: n = LEN_10;
            default: n = LEN_14;
        endcase
        return dual ? (n >> 1) : n;
    endfunction

    // Bits for which the frame clock stays high
    function automatic logic [BIT_W-1:0] osr_frame_high(logic [BIT_W-1:0] len);
        return BIT_W'((len + CNT_ONE) >> 1);
    endfunction
endpackage

// ### hdl/osr_word_if.sv
// Valid/ready word carrier between the output path's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface osr_word_if #(parameter int DW = 8);
    logic valid;
    logic ready;
    logic [DW-1:0] data;
    modport src(output valid, output data, input ready);
    modport snk(input valid, input data, output ready);
endinterface
`default_nettype wire

// ### hdl/osr_delay_line.sv
// Conversion pipeline: captures all channel codes at once, delays them.
// Assumes the codes arrive from the converter core outside this clock.
`timescale 1ns/1ps
`default_nettype none
module osr_delay_line
    import osr_pkg::*;
#(
    parameter int DW = SAMPLE_W,
    parameter int LAT = LATENCY
)(
    input wire logic clk,
    input wire logic rst,
    input wire logic [DW-1:0] din,
    osr_word_if.src dout
);
    typedef struct packed {
        logic [LAT:0][DW-1:0] pipe;
        logic [LAT:0] vld;
    } osr_dl_s;

    osr_dl_s q;
    osr_dl_s d;

    always_comb
    begin
        d = q;
        // Stage 0 samples every channel on one edge; no logic before stage 1
        d.pipe = {q.pipe[LAT-1:0], din};
        d.vld = {q.vld[LAT-1:0], 1'b1};
        if (rst)
        begin
            d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        q <= d;
    end

    // Converter cannot stall, so ready is only observed by the top
    assign dout.valid = q.vld[LAT];
    assign dout.data = q.pipe[LAT];
endmodule
`default_nettype wire

// ### hdl/osr_fifo.sv
// Small word buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module osr_fifo
    import osr_pkg::*;
#(
    parameter int DW = WORD_W,
    parameter int DEPTH = BUF_DEPTH
)(
    input wire logic clk,
    input wire logic rst,
    osr_word_if.snk wr,
    osr_word_if.src rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } osr_ff_s;

    osr_ff_s q;
    osr_ff_s d;
    logic push;
    logic pop;

    assign wr.ready = (q.cnt != (AW+1)'(DEPTH));
    assign rd.valid = (q.cnt != '0);
    assign rd.data = q.mem[q.rp];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = wr.data;
            d.wp = AW'(q.wp + 1'b1);
        end
        if (pop)
        begin
            d.rp = AW'(q.rp + 1'b1);
        end
        d.cnt = (AW+1)'(q.cnt + push - pop);
        if (rst)
        begin
            d = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        q <= d;
    end
endmodule
`default_nettype wire

// ### tb/osr_monitor.sv
// Port checker for the serial output path.
// Assumes lanes and both serial clocks leave flops on lclk.
`timescale 1ns/1ps
`default_nettype none
module osr_monitor #(
    parameter int NCHAN = 8
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic lclk,
    input wire logic [2*NCHAN-1:0] lane_out,
    input wire logic bit_clk,
    input wire logic frame_clk,
    input wire logic accept
);
    logic fc_q;
    logic seen_q;
    logic [4:0] per_q;
    logic [4:0] hi_q;
    logic [3:0] run_q;
    wire logic rise = frame_clk && !fc_q;
    // Judged frame by frame, so mode changes need no tracking here
    always_ff @(posedge lclk)
    begin
        fc_q <= frame_clk;
        seen_q <= !sys_rst && (seen_q || rise);
        run_q <= sys_rst ? 4'h0 : run_q + {3'h0, run_q != 4'h8};
        per_q <= rise ? 5'h01 : per_q + 5'h01;
        hi_q <= rise ? 5'h01 : hi_q + {4'h0, frame_clk};
    end
    a_accept_rst: assert property (@(posedge mclk) sys_rst |=> !accept)
        else $error("accept high in reset");
    a_accept_back: assert property (@(posedge mclk) disable iff (sys_rst)
        !accept |-> ##[1:40] accept) else $error("buffer never drains");
    a_lane_rst: assert property (@(posedge lclk) sys_rst [*6] |-> lane_out == '0)
        else $error("lanes busy in reset");
    a_clk_rst: assert property (@(posedge lclk) sys_rst [*6] |-> !bit_clk && !frame_clk)
        else $error("clocks busy in reset");
    a_bit_toggle: assert property (@(posedge lclk) disable iff (sys_rst)
        run_q == 4'h8 |-> bit_clk != $past(bit_clk)) else $error("bit clock stalled");
    a_frame_len: assert property (@(posedge lclk) disable iff (sys_rst)
        rise && seen_q |-> per_q inside {5'h05, 5'h06, 5'h07, 5'h0a, 5'h0c, 5'h0e})
        else $error("bad frame length");
    a_frame_high: assert property (@(posedge lclk) disable iff (sys_rst)
        rise && seen_q |-> hi_q == (per_q + 5'h01) >> 1) else $error("bad frame high");
    a_frame_min: assert property (@(posedge lclk) disable iff (sys_rst)
        $rose(frame_clk) |=> frame_clk [*2]) else $error("short frame pulse");
    c_single: cover property (@(posedge lclk) rise && seen_q && per_q == 5'h0e);
    c_dual: cover property (@(posedge lclk) rise && seen_q && per_q == 5'h05);
    c_drop: cover property (@(posedge mclk) $fell(accept));
endmodule
bind osr_top osr_monitor #(.NCHAN(NCHAN)) u_mon (.mclk(mclk), .sys_rst(sys_rst),
    .lclk(lclk), .lane_out(lane_out), .bit_clk(bit_clk), .frame_clk(frame_clk),
    .accept(accept));
`default_nettype wire

// ### tb/osr_rx.sv
// Receiver model: frames every lane on the frame clock rise.
// Assumes lanes change just after the rising lclk edge.
`timescale 1ns/1ps
`default_nettype none
module osr_rx
    import osr_pkg::*;
(
    input wire logic lclk,
    input wire logic [2*NCH-1:0] lane_out,
    input wire logic frame_clk,
    output logic [2*SAMPLE_W-1:0] words,
    output logic [4:0] nbits,
    output logic tick
);
    logic [2*SAMPLE_W-1:0] sr;
    logic [4:0] n;
    logic fc_q;
    wire logic rise = frame_clk && !fc_q;
    always @(posedge lclk)
    begin
        fc_q <= frame_clk;
        tick <= rise;
        n <= rise ? 5'h01 : n + 5'h01;
        if (rise)
        begin
            words <= sr;
            nbits <= n;
        end
        for (int l = 0; l < 2*NCH; l++)
            sr[l*RES_W +: RES_W] <= {rise ? 13'h0 : sr[l*RES_W +: 13], lane_out[l]};
    end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the serial output path.
// Assumes lclk runs free from the bench at 6 ns.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import osr_pkg::*;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [SAMPLE_W-1:0] code = '0;
    osr_res_e res_sel = RES_14;
    logic dual_lane = 1'b0;
    logic decim_en = 1'b0;
    logic [2*NCH-1:0] lane_out;
    logic bit_clk;
    logic frame_clk;
    logic accept;
    logic [2*SAMPLE_W-1:0] words;
    logic [4:0] nbits;
    logic tick;
    int fail_count = 0;
    int total_checks = 0;
    initial forever #10 mclk = !mclk;
    initial
    begin
        #1.3;
        forever #3 lclk = !lclk;
    end
    osr_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .ana_code(code), .res_sel(res_sel),
        .dual_lane(dual_lane), .decim_en(decim_en), .lclk(lclk), .lane_out(lane_out),
        .bit_clk(bit_clk), .frame_clk(frame_clk), .accept(accept));
    osr_rx u_rx (.lclk(lclk), .lane_out(lane_out), .frame_clk(frame_clk), .words(words),
        .nbits(nbits), .tick(tick));
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic frame;
        repeat (40)
        begin
            @(negedge lclk);
            if (tick === 1'b1)
                return;
        end
        check(14'h0, 14'h1);
    endtask
    // Channels carry distinct codes so a swapped lane shows up
    task automatic setm(input osr_res_e r, input logic d, input logic e, input logic [13:0] c);
        @(posedge mclk);
        #1;
        res_sel = r;
        dual_lane = d;
        decim_en = e;
        for (int i = 0; i < NCH; i++)
            code[i*RES_W +: RES_W] = c + 14'(i);
        repeat (80) @(posedge mclk);
        frame();
    endtask
    task automatic verify(input int tot, input logic d, input logic [13:0] c);
        logic [13:0] v;
        int h;
        h = d ? tot / 2 : tot;
        frame();
        check(14'(nbits), 14'(h));
        for (int i = 0; i < NCH; i++)
        begin
            v = (c + 14'(i)) >> (14 - tot);
            check(words[2*i*RES_W +: RES_W], d ? v >> h : v);
            if (d)
                check(words[(2*i+1)*RES_W +: RES_W], v & ((14'h1 << h) - 14'h1));
        end
    endtask
    // No PLL state input here, so decimated timing is the same at any factor
    task automatic t_decim;
        setm(RES_10, 1'b0, 1'b1, 14'h0F96);
        verify(14, 1'b0, 14'h0F96);
        setm(RES_12, 1'b1, 1'b1, 14'h2A5C);
        verify(12, 1'b1, 14'h2A5C);
    endtask
    task automatic t_modes;
        for (int d = 0; d < 2; d++)
            for (int r = 0; r < 3; r++)
            begin
                setm(osr_res_e'(r), 1'(d), 1'b0, 14'h1C3B);
                verify(14 - 2*r, 1'(d), 14'h1C3B);
            end
    endtask
    task automatic t_latency;
        time t0;
        setm(RES_14, 1'b0, 1'b0, 14'h0000);
        @(posedge mclk);
        #1;
        for (int i = 0; i < NCH; i++)
            code[i*RES_W +: RES_W] = 14'h3FF0 + 14'(i);
        t0 = $time;
        repeat (60)
        begin
            frame();
            if (words[RES_W-1:0] === 14'h3FF0)
                break;
        end
        check(14'($time - t0 >= LATENCY*20 && $time - t0 < 1200), 14'h1);
        for (int i = 1; i < NCH; i++)
            check(words[2*i*RES_W +: RES_W], 14'h3FF0 + 14'(i));
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        #1;
        // Only the serial-configured pulse is exercised; a parallel part keeps it high
        sys_rst = 1'b0;
        t_decim();
        t_modes();
        t_latency();
        close_out();
    end
    initial
    begin
        #100us;
        fail_count++;
        close_out();
    end
endmodule
`default_nettype wire
